// >>> include/bcc_map.svh
// Constants of the boost converter control register bank.
// Assumes inclusion by bare name from the design modules.
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// ****************************************
// Register placement
// ****************************************
`define BCC_CTRL_ADDR 8'h97
`define BCC_CTRL_PAGE 8'h00
`define BCC_CTRL_RST 8'h21

// ****************************************
// Field positions
// ****************************************
`define BCC_MINPW_HI 7
`define BCC_MINPW_LO 6
`define BCC_SWSIZE_BIT 5
`define BCC_RSVD_BIT 4
`define BCC_LOCK_BIT 3
`define BCC_VOUT_HI 2
`define BCC_VOUT_LO 0

// ****************************************
// Timing, in ns and derived cycles
// ****************************************
`define BCC_CLK_NS 5
`define BCC_MINPW1_NS 20
`define BCC_MINPW2_NS 40
`define BCC_MINPW3_NS 80
`define BCC_NS2CYC(ns) (((ns) + `BCC_CLK_NS - 1) / `BCC_CLK_NS)

// ****************************************
// Target voltage in millivolts per code
// ****************************************
`define BCC_MV0 12'd1800
`define BCC_MV1 12'd1900
`define BCC_MV2 12'd2000
`define BCC_MV3 12'd2100
`define BCC_MV4 12'd2400
`define BCC_MV5 12'd2700
`define BCC_MV6 12'd3000
`define BCC_MV7 12'd3300

`endif

// >>> include/bcc_pkg.sv
// Types of the boost converter control register bank.
// Assumes bcc_map.svh on the include path.
package bcc_pkg;

  // Layout of the control register
  typedef struct packed {
    logic [1:0] minPulseWidthSel;
    logic switchSizeSelect;
    logic reservedBit;
    logic adcLockstep;
    logic [2:0] outputVoltageSelect;
  } bcc_ctrl_s;

  // Special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bcc_sfr_s;

  // State of the register bank
  typedef struct packed {
    bcc_ctrl_s ctrl;
    logic [7:0] rdata;
    logic [4:0] minPulseCycles;
    logic switchSmall;
    logic adcLockstep;
    logic adcClkInvert;
    logic adcTrackAllow;
    logic bypassCtrlEnable;
    logic [11:0] targetMv;
  } bcc_state_s;

  // Phase of the pulse timer
  typedef enum logic [0:0] {
    BCC_OFF,
    BCC_ON
  } bcc_phase_e;

  // State of the pulse timer
  typedef struct packed {
    bcc_phase_e phase;
    logic [4:0] cnt;
  } bcc_pulse_s;

endpackage : bcc_pkg

// >>> logic/bcc_pulse_timer.sv
// Minimum on-time enforcer for the converter switch drive.
// Assumes reqOn comes from the control loop in the clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module bcc_pulse_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [4:0] minCycles,
  input wire logic reqOn,
  // Drive
  output logic drvOn
);

  bcc_pkg::bcc_pulse_s state_r;
  bcc_pkg::bcc_pulse_s state_nxt;

  // Hold the switch on until the minimum count runs out
  always_comb begin
    state_nxt = state_r;
    case (state_r.phase)
      bcc_pkg::BCC_OFF: begin
        if (reqOn) begin
          state_nxt.phase = bcc_pkg::BCC_ON;
          state_nxt.cnt = (minCycles == 5'h00) ? 5'h00 : minCycles - 5'h01;
        end
      end
      bcc_pkg::BCC_ON: begin
        if (state_r.cnt != 5'h00) begin
          state_nxt.cnt = state_r.cnt - 5'h01;
        end else if (!reqOn) begin
          state_nxt.phase = bcc_pkg::BCC_OFF;
        end
      end
      default: begin
        state_nxt.phase = bcc_pkg::BCC_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '{phase: bcc_pkg::BCC_OFF, cnt: 5'h00};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign drvOn = (state_r.phase == bcc_pkg::BCC_ON);

  // ****************************************
  // Checks
  // ****************************************
  a_pulse_min_on: assert property (@(posedge clk) disable iff (!rst_n)
    (!drvOn && reqOn && minCycles == 5'h04) |=> drvOn [*4])
    else $error("switch on-time shorter than minimum");

endmodule : bcc_pulse_timer
`default_nettype wire

// >>> logic/bcc_regs.sv
// Control register bank of the on-chip step-up converter.
// Assumes single-cycle SFR strobes synchronous to clk.
//
// Notes on behaviour
// - Passive diode enable set turns off bypass switch control circuits.
// - Bits 7:6 pick minimum pulse: none, 20, 40 or 80 ns.
// - Bit 5 low picks large switches, high picks small switches.
// - Bit 3 locks ADC tracking and clock to the switching cycle.
// - Bits 2:0 pick target 1.8 to 3.3 V per fixed table.
// - Register at address 0x97, page 0x0; reset gives small switches, 1.9 V.
// - ADC clock inversion acts only while lockstep is on.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module bcc_regs #(
  parameter int CLK_NS = `BCC_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // SFR bus
  input wire bcc_pkg::bcc_sfr_s sfr,
  output logic [7:0] sfrRdata,
  // Neighbouring register bits
  input wire logic passiveDiodeEnable,
  input wire logic adcClockInvert,
  // Switching loop
  input wire logic switchReq,
  output logic switchDrive,
  // Converter controls
  output logic [4:0] minPulseCycles,
  output logic switchSmall,
  output logic adcLockstep,
  output logic adcClkInvert,
  output logic adcTrackAllow,
  output logic bypassCtrlEnable,
  output logic [11:0] targetMv
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (CLK_NS != `BCC_CLK_NS) begin : g_bad_clk
    $error("bcc_regs: timing table is built for a 5 ns clock");
  end

  localparam logic [4:0] MinPw1Cyc = 5'(`BCC_NS2CYC(`BCC_MINPW1_NS));
  localparam logic [4:0] MinPw2Cyc = 5'(`BCC_NS2CYC(`BCC_MINPW2_NS));
  localparam logic [4:0] MinPw3Cyc = 5'(`BCC_NS2CYC(`BCC_MINPW3_NS));

  bcc_pkg::bcc_state_s state_r;
  bcc_pkg::bcc_state_s state_nxt;
  logic ctrlHit;
  logic drvOn;

  // Address and page decode
  assign ctrlHit = (sfr.addr == `BCC_CTRL_ADDR) && (sfr.page == `BCC_CTRL_PAGE);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    // Register write, reserved bit stored as written
    if (sfr.wr && ctrlHit) begin
      state_nxt.ctrl = bcc_pkg::bcc_ctrl_s'(sfr.wdata);
    end
    // Read data, zero for any other address
    state_nxt.rdata = (sfr.rd && ctrlHit) ? 8'(state_r.ctrl) : 8'h00;
    // Minimum pulse width in cycles
    case (state_nxt.ctrl.minPulseWidthSel)
      2'h0: state_nxt.minPulseCycles = 5'h00;
      2'h1: state_nxt.minPulseCycles = MinPw1Cyc;
      2'h2: state_nxt.minPulseCycles = MinPw2Cyc;
      2'h3: state_nxt.minPulseCycles = MinPw3Cyc;
      default: state_nxt.minPulseCycles = 5'h00;
    endcase
    state_nxt.switchSmall = state_nxt.ctrl.switchSizeSelect;
    state_nxt.adcLockstep = state_nxt.ctrl.adcLockstep;
    // Inversion applies only in lockstep; a zero bit means inverted
    state_nxt.adcClkInvert = state_nxt.ctrl.adcLockstep && !adcClockInvert;
    // Track only in the quiet part of the cycle when locked
    state_nxt.adcTrackAllow = !state_nxt.ctrl.adcLockstep || !drvOn;
    state_nxt.bypassCtrlEnable = !passiveDiodeEnable;
    // Target voltage table
    case (state_nxt.ctrl.outputVoltageSelect)
      3'h0: state_nxt.targetMv = `BCC_MV0;
      3'h1: state_nxt.targetMv = `BCC_MV1;
      3'h2: state_nxt.targetMv = `BCC_MV2;
      3'h3: state_nxt.targetMv = `BCC_MV3;
      3'h4: state_nxt.targetMv = `BCC_MV4;
      3'h5: state_nxt.targetMv = `BCC_MV5;
      3'h6: state_nxt.targetMv = `BCC_MV6;
      3'h7: state_nxt.targetMv = `BCC_MV7;
      default: state_nxt.targetMv = `BCC_MV1;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r.ctrl <= bcc_pkg::bcc_ctrl_s'(`BCC_CTRL_RST);
      state_r.rdata <= 8'h00;
      state_r.minPulseCycles <= 5'h00;
      state_r.switchSmall <= 1'b1;
      state_r.adcLockstep <= 1'b0;
      state_r.adcClkInvert <= 1'b0;
      state_r.adcTrackAllow <= 1'b1;
      state_r.bypassCtrlEnable <= 1'b1;
      state_r.targetMv <= `BCC_MV1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Minimum on-time of the switch drive
  bcc_pulse_timer u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .minCycles(state_r.minPulseCycles),
    .reqOn(switchReq),
    .drvOn(drvOn)
  );

  // Outputs straight from flops
  assign sfrRdata = state_r.rdata;
  assign switchDrive = drvOn;
  assign minPulseCycles = state_r.minPulseCycles;
  assign switchSmall = state_r.switchSmall;
  assign adcLockstep = state_r.adcLockstep;
  assign adcClkInvert = state_r.adcClkInvert;
  assign adcTrackAllow = state_r.adcTrackAllow;
  assign bypassCtrlEnable = state_r.bypassCtrlEnable;
  assign targetMv = state_r.targetMv;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_value_ok: assert property ($rose(rst_n) |-> state_r.ctrl == 8'h21 && switchSmall && targetMv == 12'd1900)
    else $error("reset value wrong");
  a_write_read_back: assert property ((sfr.wr && ctrlHit) ##1 !sfr.wr ##1 (sfr.rd && ctrlHit && !sfr.wr) |=>
    sfrRdata == $past(sfr.wdata, 3))
    else $error("read back differs from write");
  a_page_gate_off: assert property ((sfr.wr && sfr.page != 8'h00) |=> $stable(state_r.ctrl))
    else $error("write on other page changed register");
  a_minpw_count: assert property ((sfr.wr && ctrlHit && sfr.wdata[7:6] == 2'h3) |=> minPulseCycles == 5'h10)
    else $error("80 ns not 16 cycles");
  a_switch_size: assert property ((sfr.wr && ctrlHit) |=> switchSmall == $past(sfr.wdata[5]))
    else $error("switch size not following bit 5");
  a_invert_gated: assert property (!state_r.ctrl.adcLockstep |-> ##1 !adcClkInvert || $past(sfr.wr))
    else $error("inversion active without lockstep");
  a_track_quiet: assert property ((adcLockstep && drvOn && $stable(drvOn) && $stable(adcLockstep)) |->
    ##0 1'b1 ##1 (!adcTrackAllow || !drvOn || !adcLockstep || $changed(drvOn)))
    else $error("tracking during switch on-time");
  a_passive_diode: assert property (passiveDiodeEnable |=> !bypassCtrlEnable)
    else $error("bypass control still enabled in passive diode mode");
  a_voltage_top: assert property ((sfr.wr && ctrlHit && sfr.wdata[2:0] == 3'h7) |=> targetMv == 12'd3300)
    else $error("code 7 not 3.3 V");
  a_voltage_low: assert property ((sfr.wr && ctrlHit && sfr.wdata[2:0] == 3'h0) |=> targetMv == 12'h708)
    else $error("code 0 not 1.8 V");
  a_voltage_two: assert property ((sfr.wr && ctrlHit && sfr.wdata[2:0] == 3'h2) |=> targetMv == 12'h7D0)
    else $error("code 2 not 2.0 V");
  a_voltage_jump: assert property ((sfr.wr && ctrlHit && sfr.wdata[2:0] == 3'h4) |=> targetMv == 12'h960)
    else $error("code 4 not 2.4 V");

  // ****************************************
  // Field and side-input checks
  // ****************************************

  // Read data returns to zero between reads
  a_rdata_idle: assert property (!(sfr.rd && ctrlHit) |=> sfrRdata == 8'h00)
    else $error("read data not cleared");
  // Register holds without a write hit
  a_ctrl_stable: assert property (!(sfr.wr && ctrlHit) |=> $stable(state_r.ctrl))
    else $error("register changed without write");

  // Pulse code to cycle count
  a_minpw_zero: assert property ((sfr.wr && ctrlHit && sfr.wdata[7:6] == 2'h0) |=> minPulseCycles == 5'h00)
    else $error("code 0 not zero cycles");
  a_minpw_short: assert property ((sfr.wr && ctrlHit && sfr.wdata[7:6] == 2'h1) |=> minPulseCycles == 5'h04)
    else $error("20 ns not 4 cycles");
  a_minpw_mid: assert property ((sfr.wr && ctrlHit && sfr.wdata[7:6] == 2'h2) |=> minPulseCycles == 5'h08)
    else $error("40 ns not 8 cycles");
  // Drive stays off without a request
  a_drive_idle: assert property ((!switchReq && !switchDrive) |=> !switchDrive)
    else $error("switch on without request");

  // Lockstep bit and tracking window
  a_lockstep_bit: assert property ((sfr.wr && ctrlHit) |=> adcLockstep == $past(sfr.wdata[3]))
    else $error("lockstep not following bit 3");
  a_track_idle: assert property (((!drvOn || !state_r.ctrl.adcLockstep) && !(sfr.wr && ctrlHit)) |=>
    adcTrackAllow)
    else $error("tracking blocked while switch off or unlocked");

  // Inversion follows its input while locked
  a_invert_follow: assert property ((state_r.ctrl.adcLockstep && !(sfr.wr && ctrlHit)) |=>
    adcClkInvert == !$past(adcClockInvert))
    else $error("inversion not following its input in lockstep");
  // Bypass control back on outside passive diode mode
  a_bypass_normal: assert property (!passiveDiodeEnable |=> bypassCtrlEnable)
    else $error("bypass control off outside passive diode mode");

  // Reserved bit and divider setting are software duties, not policed here;
  // a wrong divider only spoils conversions, so no error path exists for it.

  // ****************************************
  // Coverage
  // ****************************************
  c_lockstep_on: cover property (sfr.wr && ctrlHit && sfr.wdata[3]);
  c_minpw_used: cover property (minPulseCycles == 5'h08 && $rose(switchDrive));
  c_read_back: cover property (sfr.rd && ctrlHit);
  c_passive_mode: cover property ($rose(passiveDiodeEnable));
  c_large_switch: cover property ($fell(switchSmall));

endmodule : bcc_regs
`default_nettype wire

// >>> dv/bcc_sfr_host.sv
// Software-side model that drives the SFR bus of the converter bank.
// Assumes one caller at a time; strobes change at falling edges.
`timescale 1ns/10ps
`default_nettype none

module bcc_sfr_host (
  // Clock
  input wire logic clk,
  // SFR bus
  output var bcc_pkg::bcc_sfr_s sfr
);
  // ADC divider field as software keeps it beside the register
  logic [4:0] adcClockDividerField = 5'h1F;

  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    sfr = '0;
  end

  // One-cycle write, reserved bit kept low
  task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(negedge clk);
    sfr.addr = a;
    sfr.page = pg;
    sfr.wdata = d & 8'hEF;
    sfr.wr = 1'b1;
    // Divider cleared whenever lockstep is written on
    adcClockDividerField = d[3] ? 5'h00 : 5'h1F;
    @(negedge clk);
    sfr.wr = 1'b0;
    sfr.wdata = ~sfr.wdata; // No stale data after release
    sfr.addr = ~a;
  endtask : wr

  // One-cycle read strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] pg);
    @(negedge clk);
    sfr.addr = a;
    sfr.page = pg;
    sfr.rd = 1'b1;
    @(negedge clk);
    sfr.rd = 1'b0;
    sfr.addr = ~a;
  endtask : rd
endmodule : bcc_sfr_host
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the converter control register bank.
// Assumes bcc_pkg compiled and bcc_map.svh on the include path.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk;
  logic rst_n;
  logic passiveDiodeEnable;
  logic adcClockInvert;
  logic switchReq;
  bcc_pkg::bcc_sfr_s sfr;
  logic [7:0] sfrRdata;
  logic switchDrive;
  logic [4:0] minPulseCycles;
  logic switchSmall;
  logic adcLockstep;
  logic adcClkInvert;
  logic adcTrackAllow;
  logic bypassCtrlEnable;
  logic [11:0] targetMv;
  int errors = 0;
  int cmp_count = 0;
  int seed = 15828;
  int hi;
  int lo;
  logic rdSeen = 1'b0;
  logic [7:0] d;
  logic [7:0] rdQ[$];
  logic [11:0] mvTab[8] = '{12'h708, 12'h76C, 12'h7D0, 12'h834, 12'h960, 12'hA8C, 12'hBB8, 12'hCE4};
  logic [4:0] pwTab[4] = '{5'h00, 5'h04, 5'h08, 5'h10};

  // ****************************************
  // Design and partner
  // ****************************************
  bcc_regs i_bcc_regs (.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfrRdata(sfrRdata),
    .passiveDiodeEnable(passiveDiodeEnable), .adcClockInvert(adcClockInvert),
    .switchReq(switchReq), .switchDrive(switchDrive), .minPulseCycles(minPulseCycles),
    .switchSmall(switchSmall), .adcLockstep(adcLockstep), .adcClkInvert(adcClkInvert),
    .adcTrackAllow(adcTrackAllow), .bypassCtrlEnable(bypassCtrlEnable), .targetMv(targetMv));
  bcc_sfr_host i_bcc_sfr_host (.clk(clk), .sfr(sfr));

  // ****************************************
  // Checking
  // ****************************************
  // Compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Note expected read data, then issue the read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] exp);
    rdQ.push_back(exp);
    i_bcc_sfr_host.rd(a, pg);
  endtask : rd_chk

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Read data monitor, one cycle after each strobe
  always @(posedge clk) rdSeen <= sfr.rd & rst_n;
  always @(negedge clk) begin
    if (rdSeen === 1'b1) begin
      check("sfrRdata", {8'h00, sfrRdata}, {8'h00, rdQ.pop_front()});
    end
  end

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    passiveDiodeEnable = 1'b0;
    adcClockInvert = 1'b1;
    switchReq = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // Reset state usable as is
    check("switchSmall", 16'(switchSmall), 16'h0001);
    check("targetMv", 16'(targetMv), 16'h076C);
    check("minPulse", 16'(minPulseCycles), 16'h0000);
    check("bypass", 16'(bypassCtrlEnable), 16'h0001);
    rd_chk(8'h97, 8'h00, 8'h21);
    // Every voltage and pulse code with random bits 5 and 3, reserved bit low
    for (int i = 0; i < 32; i++) begin
      d = 8'($random(seed));
      d[7:6] = i[4:3];
      d[4] = 1'b0;
      d[2:0] = i[2:0];
      passiveDiodeEnable = 1'($random(seed));
      adcClockInvert = 1'($random(seed));
      i_bcc_sfr_host.wr(8'h97, 8'h00, d);
      check("targetMv", 16'(targetMv), 16'(mvTab[d[2:0]]));
      check("minPulse", 16'(minPulseCycles), 16'(pwTab[d[7:6]]));
      check("switchSmall", 16'(switchSmall), 16'(d[5]));
      check("lockstep", 16'(adcLockstep), 16'(d[3]));
      check("clkInvert", 16'(adcClkInvert), 16'(d[3] & ~adcClockInvert));
      check("bypass", 16'(bypassCtrlEnable), 16'(!passiveDiodeEnable));
      check("adcDivider", 16'(adcLockstep ? i_bcc_sfr_host.adcClockDividerField : 5'h00), 16'h0000);
      rd_chk(8'h97, 8'h00, d);
    end
    // Neighbouring address and other page are refused
    i_bcc_sfr_host.wr(8'h96, 8'h00, 8'hC0);
    i_bcc_sfr_host.wr(8'h97, 8'h01, 8'hC0);
    rd_chk(8'h97, 8'h00, d);
    rd_chk(8'h96, 8'h00, 8'h00);
    // Minimum on-time of each code, lockstep holding off tracking
    passiveDiodeEnable = 1'b0;
    for (int k = 0; k < 4; k++) begin
      i_bcc_sfr_host.wr(8'h97, 8'h00, {k[1:0], 6'h08});
      @(negedge clk);
      switchReq = 1'b1;
      @(negedge clk);
      switchReq = 1'b0;
      hi = 0;
      lo = 0;
      repeat (40) begin
        hi += (switchDrive === 1'b1);
        lo += (adcTrackAllow === 1'b0);
        @(negedge clk);
      end
      check("driveCycles", 16'(hi), (k == 0) ? 16'h0001 : 16'(pwTab[k]));
      check("trackLow", 16'(lo), (k == 0) ? 16'h0001 : 16'(pwTab[k]));
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
